// File: timer_clock_pkg.sv
package timer_clock_pkg;
  localparam logic [7:0] clock_control_second_addr = 8'hE4;
  localparam logic [7:0] clock_control_second_reset = 8'h00;
  localparam logic [3:0] select_bits_reset = 4'h0;
  localparam logic [3:0] unused_read_value = 4'h0;
  localparam int four_low_bit = 0;
  localparam int four_high_bit = 1;
  localparam int five_low_bit = 2;
  localparam int five_high_bit = 3;

  // Register bus request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Tick choices for one timer
  typedef struct packed {
    logic split;
    logic ext_sel;
    logic ext_tick;
  } timer_cfg_s;
endpackage

// File: timer_clock_source_select.sv
// Contract
// - Timer four low: 0 external choice, 1 sysclk
// - Low select covers whole timer unless split
// - Split timer four high: 1 sysclk, 0 external
// - Timer five low selects likewise, whole or low
// - Split timer five high: 1 selects sysclk
// - Upper four bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
module timer_clock_source_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register bus
  input wire timer_clock_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // Timer configuration and external tick sources
  input wire logic sys_tick,
  input wire timer_clock_pkg::timer_cfg_s timer_four_cfg,
  input wire timer_clock_pkg::timer_cfg_s timer_five_cfg,
  input wire logic [1:0] timer_four_src_ticks,
  input wire logic [1:0] timer_five_src_ticks,
  // Count enables per byte
  output logic timer_four_low_tick,
  output logic timer_four_high_tick,
  output logic timer_five_low_tick,
  output logic timer_five_high_tick,
  // Live selections
  output logic [3:0] select_bits
);
  // Selection register and its next value
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;

  // Registered read data and its next value
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Registered count enables and their next values
  logic t4l_r;
  logic t4l_nxt;
  logic t4h_r;
  logic t4h_nxt;
  logic t5l_r;
  logic t5l_nxt;
  logic t5h_r;
  logic t5h_nxt;

  // Register decode
  logic hit;
  logic wr_hit;
  logic rd_hit;

  // Select bit positions must lie inside the writable nibble
  if (timer_clock_pkg::four_low_bit >= $bits(sel_r) ||
      timer_clock_pkg::four_high_bit >= $bits(sel_r) ||
      timer_clock_pkg::five_low_bit >= $bits(sel_r) ||
      timer_clock_pkg::five_high_bit >= $bits(sel_r)) begin : g_bad_layout
    $error("select bit position outside writable field");
  end

  // Source picked by the timer's external clock select
  function automatic logic ext_source(input logic ext_sel, input logic [1:0] src);
    logic ext_t;
    ext_t = src[0];
    if (ext_sel) begin
      ext_t = src[1];
    end
    ext_source = ext_t;
  endfunction

  // System tick when selected, else the external-select source
  function automatic logic pick(input logic sys_sel, input logic sys_t, input logic ext_sel,
                                input logic [1:0] src);
    logic chosen;
    chosen = ext_source(ext_sel, src);
    if (sys_sel) begin
      chosen = sys_t;
    end
    pick = chosen;
  endfunction

  // Only the one register address is decoded
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = addr == timer_clock_pkg::clock_control_second_addr;
  endfunction

  always_comb begin
    hit = addr_hit(req.addr);
    wr_hit = req.wr && hit;
    rd_hit = req.rd && hit;
  end

  // Upper write bits are dropped here
  always_comb begin
    sel_nxt = sel_r;
    if (wr_hit) begin
      sel_nxt = req.wdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= timer_clock_pkg::select_bits_reset;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Read data stands one cycle, zero otherwise
  always_comb begin
    rdata_nxt = '0;
    if (rd_hit) begin
      rdata_nxt = {timer_clock_pkg::unused_read_value, sel_r};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= timer_clock_pkg::clock_control_second_reset;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Timer four low byte: own select in both modes
  always_comb begin
    t4l_nxt = pick(
      sel_r[timer_clock_pkg::four_low_bit],
      sys_tick,
      timer_four_cfg.ext_sel,
      timer_four_src_ticks
    );
  end

  // Timer four high byte: own select only when split
  always_comb begin
    if (timer_four_cfg.split) begin
      t4h_nxt = pick(
        sel_r[timer_clock_pkg::four_high_bit],
        sys_tick,
        timer_four_cfg.ext_sel,
        timer_four_src_ticks
      );
    end else begin
      t4h_nxt = pick(
        sel_r[timer_clock_pkg::four_low_bit],
        sys_tick,
        timer_four_cfg.ext_sel,
        timer_four_src_ticks
      );
    end
  end

  // Timer five low byte: own select in both modes
  always_comb begin
    t5l_nxt = pick(
      sel_r[timer_clock_pkg::five_low_bit],
      sys_tick,
      timer_five_cfg.ext_sel,
      timer_five_src_ticks
    );
  end

  // Timer five high byte: own select only when split
  always_comb begin
    if (timer_five_cfg.split) begin
      t5h_nxt = pick(
        sel_r[timer_clock_pkg::five_high_bit],
        sys_tick,
        timer_five_cfg.ext_sel,
        timer_five_src_ticks
      );
    end else begin
      t5h_nxt = pick(
        sel_r[timer_clock_pkg::five_low_bit],
        sys_tick,
        timer_five_cfg.ext_sel,
        timer_five_src_ticks
      );
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t4l_r <= 1'b0;
    end else begin
      t4l_r <= t4l_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t4h_r <= 1'b0;
    end else begin
      t4h_r <= t4h_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t5l_r <= 1'b0;
    end else begin
      t5l_r <= t5l_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      t5h_r <= 1'b0;
    end else begin
      t5h_r <= t5h_nxt;
    end
  end

  // Outputs come straight from the flip-flops
  assign rdata = rdata_r;
  assign select_bits = sel_r;
  assign timer_four_low_tick = t4l_r;
  assign timer_four_high_tick = t4h_r;
  assign timer_five_low_tick = t5l_r;
  assign timer_five_high_tick = t5h_r;

  // The ext_tick field is carried for the timers themselves, not used here
endmodule
`default_nettype wire

// File: tcs_props.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_chk (input wire logic mclk, rst_b, sys_tick, timer_four_low_tick, timer_four_high_tick,
  timer_five_low_tick, timer_five_high_tick, input wire logic [7:0] rdata, input wire logic [3:0] select_bits,
  input wire logic [1:0] timer_four_src_ticks, timer_five_src_ticks,
  input wire timer_clock_pkg::timer_cfg_s timer_four_cfg, timer_five_cfg);
  logic e4, e5;
  assign e4 = timer_four_src_ticks[timer_four_cfg.ext_sel];
  assign e5 = timer_five_src_ticks[timer_five_cfg.ext_sel];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_four_low_src: assert property (timer_four_low_tick == $past(select_bits[0] ? sys_tick : e4)) else $error("t4 lo");
  a_four_whole_timer: assert property (!$past(timer_four_cfg.split) |-> timer_four_high_tick == timer_four_low_tick) else $error("t4 whole");
  a_four_high_split: assert property ($past(timer_four_cfg.split) |-> timer_four_high_tick == $past(select_bits[1] ? sys_tick : e4)) else $error("t4 hi");
  a_five_low_src: assert property (timer_five_low_tick == $past(select_bits[2] ? sys_tick : e5)) else $error("t5 lo");
  a_five_high_sys: assert property ($past(timer_five_cfg.split && select_bits[3]) |-> timer_five_high_tick == $past(sys_tick)) else $error("t5 hi");
  a_five_high_ext: assert property ($past(timer_five_cfg.split && !select_bits[3]) |-> timer_five_high_tick == $past(e5)) else $error("t5 ext");
  a_upper_zero: assert property (rdata[7:4] == 4'h0) else $error("upper bits");
  cover property (timer_four_cfg.split && select_bits[1] && timer_four_high_tick);
  cover property (rdata != 8'h00);
  cover property (timer_five_high_tick && !timer_five_low_tick);
endmodule
bind timer_clock_source_select tcs_chk i_tcs_chk (.*);
`default_nettype wire

// File: timer_clock_source_select_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module timer_clock_source_select_tb_top;
  logic mclk = 0, rst_b = 0, sys_tick = 0;
  logic [1:0] s4 = 2'h0, s5 = 2'h0;
  wire logic [3:0] t;
  wire logic [3:0] sb;
  logic [3:0] x;
  wire logic [7:0] rdata;
  int miscompares = 0, comparisons = 0;
  timer_clock_pkg::reg_req_s req = '0;
  timer_clock_pkg::timer_cfg_s c4 = '0, c5 = '0;
  timer_clock_source_select i_timer_clock_source_select (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .sys_tick(sys_tick), .timer_four_cfg(c4), .timer_five_cfg(c5), .timer_four_src_ticks(s4),
    .timer_five_src_ticks(s5), .timer_four_low_tick(t[0]), .timer_four_high_tick(t[1]),
    .timer_five_low_tick(t[2]), .timer_five_high_tick(t[3]), .select_bits(sb));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; read data is valid on return
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) req = '{w, !w, a, d};
    @(negedge mclk) req = '0;
  endtask
  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #50 mclk = ~mclk;
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst_b = 1;
    acc(0, 8'hE4, 8'h00); chk(rdata, 8'h00);
    acc(1, 8'hE4, 8'hFA); acc(0, 8'hE4, 8'h00); chk(rdata, 8'h0A);
    acc(1, 8'hE5, 8'h05); acc(0, 8'hE5, 8'h00); chk(rdata, 8'h00);
    chk({4'h0, sb}, 8'h0A);
    $display("register test done");
    for (int i = 0; i < 64; i++) begin
      acc(1, 8'hE4, {4'h0, i[3:0]});
      c4 = '{i[4], i[5], 1'b0};
      c5 = c4;
      s4 = 2'h2;
      s5 = 2'h2;
      sys_tick = !i[5];
      x[0] = i[0] ? !i[5] : i[5];
      x[1] = i[4] ? (i[1] ? !i[5] : i[5]) : x[0];
      x[2] = i[2] ? !i[5] : i[5];
      x[3] = i[4] ? (i[3] ? !i[5] : i[5]) : x[2];
      @(negedge mclk) chk({4'h0, t}, {4'h0, x});
    end
    $display("tick test done");
    finish_test;
  end
endmodule
`default_nettype wire
